// ### nv_rtc_params.svh
`ifndef NV_RTC_PARAMS_SVH
`define NV_RTC_PARAMS_SVH

// special opcodes
`define OP_STORE        8'h3c
`define OP_RECALL       8'h60
`define OP_AUTOSAVE_ON  8'h59
`define OP_AUTOSAVE_OFF 8'h19
// plain defaults, the opcodes are not fixed here
`define OP_SET_WE       8'h06
`define OP_CLKREG_RD    8'h13
`define OP_CLKREG_WR    8'h12

// clock register map
`define FLAG_ADDR       4'h0
`define FLAG_R_BIT      0
`define FLAG_W_BIT      1
`define TIME_BASE       8
`define TIME_REGS       8
`define CLKREG_NUM      16
`define REG_RST         8'h00

// time register order inside the timekeeping block
`define T_SEC           0
`define T_MIN           1
`define T_HOUR          2
`define T_DOW           3
`define T_DATE          4
`define T_MON           5
`define T_YEAR          6
`define T_CENT          7

// implemented bits, the rest read as zero
`define MASK_SEC        8'h7f
`define MASK_MIN        8'h7f
`define MASK_HOUR       8'h3f
`define MASK_DOW        8'h07
`define MASK_DATE       8'h3f
`define MASK_MON        8'h1f
`define MASK_ALL        8'hff

// bcd limits
`define BCD_ZERO        8'h00
`define BCD_ONE         8'h01
`define BCD_59          8'h59
`define BCD_23          8'h23
`define BCD_7           8'h07
`define BCD_12          8'h12
`define BCD_99          8'h99
`define BCD_28          8'h28
`define BCD_29          8'h29
`define BCD_30          8'h30
`define BCD_31          8'h31
`define BCD_FEB         8'h02
`define BCD_APR         8'h04
`define BCD_JUN         8'h06
`define BCD_SEP         8'h09
`define BCD_NOV         8'h11
`define NIB_NINE        4'h9

// timing
`define CLK_PERIOD_NS   100
`define SECOND_NS       1000000000
`define REFRESH_MS      20
`define TICK_CYCLES     (`SECOND_NS / `CLK_PERIOD_NS)
`define TICK_W          24

`endif

// ### nv_rtc_pkg.sv
package nv_rtc_pkg;
    // byte phase of a serial frame
    typedef enum logic [1:0] {
        PH_OPCODE = 2'b00,
        PH_ADDR   = 2'b01,
        PH_DATA   = 2'b10
    } link_phase_e;
    typedef logic [7:0] byte_t;
endpackage

// ### nv_special_cmd_rtc.sv
`timescale 1ns/100ps
`include "nv_rtc_params.svh"
module nv_special_cmd_rtc
    import nv_rtc_pkg::*;
#(
    parameter int TICK_CYCLES = `TICK_CYCLES
) (
    // system clock and reset
    input  wire logic CLK,
    input  wire logic ARST_N,
    // serial link, clocked by the master
    input  wire logic SCK,
    input  wire logic CS_N,
    input  wire logic HOLD_N,
    input  wire logic SI,
    output logic      SO_O,
    output logic      SO_OE_N,
    // nonvolatile array control
    input  wire logic NV_DONE,
    output logic      STORE_REQ,
    output logic      RECALL_REQ,
    output logic      NV_BUSY,
    output logic      AUTOSAVE_EN,
    output logic      WRITE_EN_LATCH
);

    // ---------------- link side, SCK domain ----------------
    logic        link_rst_n;
    logic [2:0]  bit_r;
    link_phase_e phase_r;
    link_phase_e phase_nxt;
    byte_t       shift_r;
    byte_t       rx_byte;
    byte_t       op_r;
    logic [3:0]  addr_r;
    logic        cmd_tgl_r;
    logic        over_tgl_r;
    logic [15:0] mask_r;
    byte_t       stage_r [`CLKREG_NUM];
    logic        shift_en;
    logic        byte_end;
    logic        first_bit;
    logic        first_extra;
    logic        stage_wr;
    logic        rd_phase;
    logic        rd_bit;
    logic        so_off;
    byte_t       usr_r [`CLKREG_NUM];

    // deselect restarts the frame counters; hold freezes them
    assign link_rst_n  = ARST_N & ~CS_N;
    assign shift_en    = ~CS_N & HOLD_N;
    assign rx_byte     = {shift_r[6:0], SI};
    assign byte_end    = (bit_r == 3'h7);
    assign first_bit   = (phase_r == PH_OPCODE) && (bit_r == 3'h0);
    assign first_extra = (phase_r == PH_ADDR) && (bit_r == 3'h0);
    assign stage_wr    = byte_end && (phase_r == PH_DATA)
                         && (op_r == `OP_CLKREG_WR);
    assign rd_phase    = (phase_r == PH_DATA) && (op_r == `OP_CLKREG_RD);
    // visible registers only change between frames, so they sit still here
    assign rd_bit      = usr_r[addr_r][~bit_r];
    assign so_off      = ~ARST_N | CS_N | ~HOLD_N;

    // byte phase sequence
    always_comb begin
        case (phase_r)
            PH_OPCODE: phase_nxt = PH_ADDR;
            PH_ADDR:   phase_nxt = PH_DATA;
            default:   phase_nxt = PH_DATA;
        endcase
    end

    // bit and phase counters
    always_ff @(posedge SCK or negedge link_rst_n) begin
        if (!link_rst_n) begin
            bit_r   <= 3'h0;
            phase_r <= PH_OPCODE;
            shift_r <= 8'h00;
        end else if (HOLD_N) begin
            bit_r   <= bit_r + 3'h1;
            shift_r <= rx_byte;
            if (byte_end) begin
                phase_r <= phase_nxt;
            end
        end
    end

    // opcode, address and staging; kept across deselect for the CLK side
    always_ff @(posedge SCK or negedge ARST_N) begin
        if (!ARST_N) begin
            op_r       <= 8'h00;
            addr_r     <= 4'h0;
            cmd_tgl_r  <= 1'b0;
            over_tgl_r <= 1'b0;
            mask_r     <= 16'h0000;
        end else if (shift_en) begin
            if (first_bit) begin
                mask_r <= 16'h0000;
            end
            if (first_extra) begin
                over_tgl_r <= ~over_tgl_r;
            end
            if (byte_end && phase_r == PH_OPCODE) begin
                op_r      <= rx_byte;
                cmd_tgl_r <= ~cmd_tgl_r;
            end
            if (byte_end && phase_r == PH_ADDR) begin
                addr_r <= rx_byte[3:0];
            end
            if (byte_end && phase_r == PH_DATA) begin
                addr_r <= addr_r + 4'h1;
            end
            if (stage_wr) begin
                mask_r[addr_r] <= 1'b1;
            end
        end
    end

    // write staging memory, applied on the CLK side at deselect
    always_ff @(posedge SCK) begin
        if (shift_en && stage_wr) begin
            stage_r[addr_r] <= rx_byte;
        end
    end

    // data bit kept through a hold, so it is still valid once resumed
    always_ff @(negedge SCK or negedge link_rst_n) begin
        if (!link_rst_n) begin
            SO_O <= 1'b0;
        end else if (HOLD_N) begin
            SO_O <= rd_bit;
        end
    end

    // enable floated at once on hold or idle; it drives again only from
    // the next falling edge, so a host must not sample right at resume
    always_ff @(negedge SCK or posedge so_off) begin
        if (so_off) begin
            SO_OE_N <= 1'b1;
        end else begin
            SO_OE_N <= ~rd_phase;
        end
    end

    // ---------------- crossing into CLK domain ----------------
    logic [2:0] cs_sync_r;
    logic [2:0] cmd_sync_r;
    logic [2:0] over_sync_r;
    logic       cs_q_r;
    logic       cmd_q_r;
    logic       over_q_r;
    logic       cs_chg;
    logic       cs_rise;
    logic       cs_fall;
    logic       cmd_evt;
    logic       over_evt;

    // a change counts once second and third stage agree
    function automatic logic sync_chg(input logic [2:0] s, input logic q);
        sync_chg = (s[2] == s[1]) && (s[2] != q);
    endfunction

    assign cs_chg   = sync_chg(cs_sync_r, cs_q_r);
    assign cs_rise  = cs_chg && cs_sync_r[2];
    assign cs_fall  = cs_chg && !cs_sync_r[2];
    assign cmd_evt  = sync_chg(cmd_sync_r, cmd_q_r);
    assign over_evt = sync_chg(over_sync_r, over_q_r);

    // three-stage synchronisers for select and the two toggles
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cs_sync_r   <= 3'h7;
            cmd_sync_r  <= 3'h0;
            over_sync_r <= 3'h0;
            cs_q_r      <= 1'b1;
            cmd_q_r     <= 1'b0;
            over_q_r    <= 1'b0;
        end else begin
            cs_sync_r   <= {cs_sync_r[1:0], CS_N};
            cmd_sync_r  <= {cmd_sync_r[1:0], cmd_tgl_r};
            over_sync_r <= {over_sync_r[1:0], over_tgl_r};
            cs_q_r      <= cs_chg ? cs_sync_r[2] : cs_q_r;
            cmd_q_r     <= cmd_evt ? cmd_sync_r[2] : cmd_q_r;
            over_q_r    <= over_evt ? over_sync_r[2] : over_q_r;
        end
    end

    // ---------------- command execution ----------------
    logic got8_r;
    logic got9_r;
    logic is_store;
    logic is_recall;
    logic is_on;
    logic is_off;
    logic is_special;
    logic exact8;
    logic exec_special;
    logic exec_we;
    logic wr_commit;

    assign is_store     = (op_r == `OP_STORE);
    assign is_recall    = (op_r == `OP_RECALL);
    assign is_on        = (op_r == `OP_AUTOSAVE_ON);
    assign is_off       = (op_r == `OP_AUTOSAVE_OFF);
    assign is_special   = is_store | is_recall | is_on | is_off;
    assign exact8       = cs_rise && got8_r && !got9_r;
    // a store or recall in flight blocks further special commands
    assign exec_special = exact8 && is_special
                          && WRITE_EN_LATCH && !NV_BUSY;
    assign exec_we      = exact8 && (op_r == `OP_SET_WE);
    assign wr_commit    = cs_rise && got9_r && WRITE_EN_LATCH
                          && (op_r == `OP_CLKREG_WR);

    // frame bookkeeping: the setting event wins over the frame-start clear
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            got8_r <= 1'b0;
            got9_r <= 1'b0;
        end else begin
            got8_r <= cmd_evt | (got8_r & ~cs_fall);
            got9_r <= over_evt | (got9_r & ~cs_fall);
        end
    end

    // latch, requests, busy and autosave state
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            WRITE_EN_LATCH <= 1'b0;
            STORE_REQ      <= 1'b0;
            RECALL_REQ     <= 1'b0;
            NV_BUSY        <= 1'b0;
            AUTOSAVE_EN    <= 1'b1;
        end else begin
            if (exec_we) begin
                WRITE_EN_LATCH <= 1'b1;
            end else if (exec_special || wr_commit) begin
                WRITE_EN_LATCH <= 1'b0;
            end
            STORE_REQ  <= exec_special && is_store;
            RECALL_REQ <= exec_special && is_recall;
            if (exec_special && (is_store || is_recall)) begin
                NV_BUSY <= 1'b1;
            end else if (NV_DONE) begin
                NV_BUSY <= 1'b0;
            end
            if (exec_special && is_on) begin
                AUTOSAVE_EN <= 1'b1;
            end else if (exec_special && is_off) begin
                AUTOSAVE_EN <= 1'b0;
            end
        end
    end

    // ---------------- real time clock ----------------
    byte_t               cnt_r [`TIME_REGS];
    byte_t               cnt_adv [`TIME_REGS];
    logic [`TICK_W-1:0]  tick_r;
    logic                sec_tick;
    logic                r_bit;
    logic                w_bit;
    logic                w_prev_r;
    logic                reload;
    logic                allow_upd;
    logic                c_min;
    logic                c_hour;
    logic                c_day;
    logic                c_mon;
    logic                c_year;
    logic                c_cent;
    byte_t               dim;

    // bcd step; a bad low nibble runs on to f and wraps without carry
    function automatic byte_t bcd_inc(input byte_t v, input byte_t hi,
                                      input byte_t lo);
        if (v == hi) begin
            bcd_inc = lo;
        end else if (v[3:0] == `NIB_NINE) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    // divisible by four, taken on a bcd pair
    function automatic logic bcd_div4(input byte_t v);
        if (v[4]) begin
            bcd_div4 = (v[3:0] == 4'h2) || (v[3:0] == 4'h6);
        end else begin
            bcd_div4 = (v[3:0] == 4'h0) || (v[3:0] == 4'h4)
                       || (v[3:0] == 4'h8);
        end
    endfunction

    // last day of the month, century years use the century count
    function automatic byte_t month_len(input byte_t m, input byte_t y,
                                        input byte_t c);
        logic leap;
        leap = (y == `BCD_ZERO) ? bcd_div4(c) : bcd_div4(y);
        if (m == `BCD_FEB) begin
            month_len = leap ? `BCD_29 : `BCD_28;
        end else if (m == `BCD_APR || m == `BCD_JUN || m == `BCD_SEP
                     || m == `BCD_NOV) begin
            month_len = `BCD_30;
        end else begin
            month_len = `BCD_31;
        end
    endfunction

    // implemented bits of each clock register
    function automatic byte_t reg_mask(input int idx);
        case (idx - `TIME_BASE)
            `T_SEC:  reg_mask = `MASK_SEC;
            `T_MIN:  reg_mask = `MASK_MIN;
            `T_HOUR: reg_mask = `MASK_HOUR;
            `T_DOW:  reg_mask = `MASK_DOW;
            `T_DATE: reg_mask = `MASK_DATE;
            `T_MON:  reg_mask = `MASK_MON;
            default: reg_mask = `MASK_ALL;
        endcase
    endfunction

    assign sec_tick  = (tick_r == `TICK_W'(TICK_CYCLES - 1));
    assign r_bit     = usr_r[`FLAG_ADDR][`FLAG_R_BIT];
    assign w_bit     = usr_r[`FLAG_ADDR][`FLAG_W_BIT];
    assign reload    = w_prev_r && !w_bit;
    // no refresh mid-frame, so a read never sees a half-updated set
    assign allow_upd = !r_bit && !w_bit && cs_q_r;
    assign dim       = month_len(cnt_r[`T_MON], cnt_r[`T_YEAR],
                                 cnt_r[`T_CENT]);
    assign c_min     = (cnt_r[`T_SEC] == `BCD_59);
    assign c_hour    = c_min && (cnt_r[`T_MIN] == `BCD_59);
    assign c_day     = c_hour && (cnt_r[`T_HOUR] == `BCD_23);
    assign c_mon     = c_day && (cnt_r[`T_DATE] == dim);
    assign c_year    = c_mon && (cnt_r[`T_MON] == `BCD_12);
    assign c_cent    = c_year && (cnt_r[`T_YEAR] == `BCD_99);

    // one-second advance of the whole calendar
    always_comb begin
        cnt_adv = cnt_r;
        cnt_adv[`T_SEC] = bcd_inc(cnt_r[`T_SEC], `BCD_59, `BCD_ZERO);
        if (c_min) begin
            cnt_adv[`T_MIN] = bcd_inc(cnt_r[`T_MIN], `BCD_59, `BCD_ZERO);
        end
        if (c_hour) begin
            cnt_adv[`T_HOUR] = bcd_inc(cnt_r[`T_HOUR], `BCD_23, `BCD_ZERO);
        end
        if (c_day) begin
            cnt_adv[`T_DOW]  = bcd_inc(cnt_r[`T_DOW], `BCD_7, `BCD_ONE);
            cnt_adv[`T_DATE] = bcd_inc(cnt_r[`T_DATE], dim, `BCD_ONE);
        end
        if (c_mon) begin
            cnt_adv[`T_MON] = bcd_inc(cnt_r[`T_MON], `BCD_12, `BCD_ONE);
        end
        if (c_year) begin
            cnt_adv[`T_YEAR] = bcd_inc(cnt_r[`T_YEAR], `BCD_99, `BCD_ZERO);
        end
        if (c_cent) begin
            cnt_adv[`T_CENT] = bcd_inc(cnt_r[`T_CENT], `BCD_99, `BCD_ZERO);
        end
    end

    // running counters keep time regardless of the read bit
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            tick_r   <= '0;
            w_prev_r <= 1'b0;
            for (int i = 0; i < `TIME_REGS; i++) begin
                cnt_r[i] <= `REG_RST;
            end
        end else begin
            tick_r   <= sec_tick ? '0 : tick_r + `TICK_W'(1);
            w_prev_r <= w_bit;
            for (int i = 0; i < `TIME_REGS; i++) begin
                if (reload) begin
                    cnt_r[i] <= usr_r[`TIME_BASE + i];
                end else if (sec_tick) begin
                    // masked so a runaway bad nibble never sets a spare bit
                    cnt_r[i] <= cnt_adv[i] & reg_mask(i + `TIME_BASE);
                end
            end
        end
    end

    // visible registers: frame writes first, else refresh from counters
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            for (int i = 0; i < `CLKREG_NUM; i++) begin
                usr_r[i] <= `REG_RST;
            end
        end else begin
            for (int i = 0; i < `CLKREG_NUM; i++) begin
                if (wr_commit && mask_r[i] && (i == 0 || w_bit)) begin
                    usr_r[i] <= stage_r[i] & reg_mask(i);
                end else if (allow_upd && i >= `TIME_BASE) begin
                    usr_r[i] <= cnt_r[i - `TIME_BASE];
                end
            end
        end
    end

    // ---------------- checks ----------------
    a_wel_clear: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        exec_special |=> !WRITE_EN_LATCH
    ) else $error("latch not cleared after special command");

    a_store_gate: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        STORE_REQ |-> $past(WRITE_EN_LATCH) && $past(cs_rise)
                      && $past(op_r) == `OP_STORE
    ) else $error("store requested without latch or opcode");

    a_eight_bits: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        cs_rise && got9_r |=> !STORE_REQ && !RECALL_REQ
    ) else $error("request after a frame longer than eight bits");

    a_recall_pulse: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        $rose(RECALL_REQ) |=> !RECALL_REQ ##1 NV_BUSY || $past(NV_DONE)
    ) else $error("recall request not a single pulse with busy");

    a_autosave_off: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        $fell(AUTOSAVE_EN) |-> $past(exec_special) && $past(is_off)
    ) else $error("autosave dropped without disable command");

    a_hold_float: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        !HOLD_N && !$past(HOLD_N) |-> SO_OE_N
    ) else $error("output driven during hold");

    a_freeze_time: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        r_bit && !wr_commit |=> $stable(usr_r[`TIME_BASE])
    ) else $error("visible time moved while frozen");

    a_reload_cnt: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        reload |=> cnt_r[`T_SEC] == $past(usr_r[`TIME_BASE])
    ) else $error("counters not loaded when write bit cleared");

    a_refresh_idle: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        allow_upd && !wr_commit |=> usr_r[`TIME_BASE] == $past(cnt_r[0])
    ) else $error("visible seconds not refreshed while idle");

    a_reserved_zero: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        !usr_r[`TIME_BASE][7] && usr_r[`TIME_BASE + `T_MON][7:5] == 3'h0
    ) else $error("reserved clock bit reads one");

endmodule

// ### spi_host_model.sv
`timescale 1ns/100ps
module spi_host_model
    import nv_rtc_pkg::*;
(
    // link pins toward the device
    output logic      SCK,
    output logic      CS_N,
    output logic      HOLD_N,
    output logic      SI,
    // serial output from the device
    input  wire logic SO_O,
    input  wire logic SO_OE_N
);
    logic hold_float; // stays 1 while every hold floated the output

    // idle link: mode 0, clock low, device deselected
    initial begin
        SCK = 1'b0;
        CS_N = 1'b1;
        HOLD_N = 1'b1;
        SI = 1'b0;
        hold_float = 1'b1;
    end

    // one frame of bits, msb first, 30 ns clock only inside the frame
    task automatic frame(input logic b[$], input int hold_at,
                         output byte_t rx);
        #7 CS_N = 1'b0;
        for (int i = 0; i < b.size(); i++) begin
            if (i == hold_at) begin
                #5 HOLD_N = 1'b0;
                repeat (3) begin
                    #15 SCK = 1'b1;
                    SI = ~SI;
                    #15 SCK = 1'b0;
                end
                if (SO_OE_N !== 1'b1) hold_float = 1'b0;
                #5 HOLD_N = 1'b1;
            end
            SI = b[i];
            #15 SCK = 1'b1;
            rx = {rx[6:0], SO_O};
            #15 SCK = 1'b0;
        end
        // last rise must lead the select rise by more than a system clock
        #120 CS_N = 1'b1;
        SI = ~SI; // released line must not keep its last value
        #1000;
    endtask
endmodule

// ### nv_special_cmd_rtc_tb.sv
`timescale 1ns/100ps
module nv_special_cmd_rtc_tb
    import nv_rtc_pkg::*;
;
    logic  CLK, ARST_N, NV_DONE, acc, we, as_exp, wel;
    wire   SCK, CS_N, HOLD_N, SI, SO_O, SO_OE_N;
    wire   STORE_REQ, RECALL_REQ, NV_BUSY, AUTOSAVE_EN, WRITE_EN_LATCH;
    int    fails, num_checks, seed, n_st, n_rc, s0, r0, adj, hold;
    byte_t rx, op;
    byte_t ops[4] = '{8'h3c, 8'h60, 8'h19, 8'h59};
    byte_t msk[3] = '{8'h7f, 8'h7f, 8'h3f};

    nv_special_cmd_rtc #(.TICK_CYCLES(20)) u_nv_special_cmd_rtc (
        .CLK(CLK), .ARST_N(ARST_N), .SCK(SCK), .CS_N(CS_N),
        .HOLD_N(HOLD_N), .SI(SI), .SO_O(SO_O), .SO_OE_N(SO_OE_N),
        .NV_DONE(NV_DONE), .STORE_REQ(STORE_REQ),
        .RECALL_REQ(RECALL_REQ), .NV_BUSY(NV_BUSY),
        .AUTOSAVE_EN(AUTOSAVE_EN), .WRITE_EN_LATCH(WRITE_EN_LATCH));

    spi_host_model u_spi_host_model (
        .SCK(SCK), .CS_N(CS_N), .HOLD_N(HOLD_N), .SI(SI),
        .SO_O(SO_O), .SO_OE_N(SO_OE_N));

    // system clock, 100 ns
    always #50 CLK = ~CLK;

    // count request pulses, each lasts one cycle
    always @(posedge CLK) begin
        if (STORE_REQ === 1'b1) n_st++;
        if (RECALL_REQ === 1'b1) n_rc++;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // bytes msb first; adj drops or adds one trailing bit
    task automatic send(input byte_t by[$], input int adj, input int h);
        logic b[$];
        foreach (by[k]) for (int j = 7; j >= 0; j--) b.push_back(by[k][j]);
        if (adj < 0) void'(b.pop_back());
        if (adj > 0) b.push_back(1'b1);
        u_spi_host_model.frame(b, h, rx);
    endtask

    // watchdog, far beyond the expected 70 us of traffic
    initial begin
        #3000000;
        fails++;
        conclude();
    end

    initial begin
        CLK = 1'b0;
        ARST_N = 1'b0;
        NV_DONE = 1'b0;
        seed = 32'h513377fe;
        as_exp = 1'b1;
        wel = 1'b0;
        repeat (5) @(negedge CLK);
        ARST_N = 1'b1;
        check(8'(AUTOSAVE_EN), 8'h01);
        check(8'(WRITE_EN_LATCH), 8'h00);
        // first frame no sooner than one system clock after release
        repeat (2) @(negedge CLK);
        // fixed corners first, then random opcodes and latch; hold point random throughout
        for (int it = 0; it < 16; it++) begin
            op = (it < 4) ? ops[it] : ops[$unsigned($random(seed)) % 4];
            we = (it < 7) ? (it != 4) : 1'($random(seed));
            adj = (it == 5) ? -1 : (it == 6) ? 1 : 0;
            hold = $unsigned($random(seed)) % 9 - 1;
            s0 = n_st;
            r0 = n_rc;
            // the latch carries over from a refused frame
            acc = (we || wel) && adj == 0;
            if (we) send('{8'h06}, 0, -1);
            send('{op}, adj, hold);
            if (acc && op == 8'h59) as_exp = 1'b1;
            if (acc && op == 8'h19) as_exp = 1'b0;
            wel = !acc && (we || wel);
            check(8'(WRITE_EN_LATCH), 8'(wel));
            check(8'(n_st - s0), 8'(acc && op == 8'h3c));
            check(8'(n_rc - r0), 8'(acc && op == 8'h60));
            check(8'(AUTOSAVE_EN), 8'(as_exp));
            check(8'(NV_BUSY), 8'(acc && (op == 8'h3c || op == 8'h60)));
            @(negedge CLK) NV_DONE = 1'b1;
            @(negedge CLK) NV_DONE = 1'b0;
            @(negedge CLK);
            check(8'(NV_BUSY), 8'h00);
        end
        // set the write bit, then fill sec, min, hour with all ones
        send('{8'h06}, 0, -1);
        send('{8'h12, 8'h00, 8'h02}, 0, -1);
        send('{8'h06}, 0, -1);
        send('{8'h12, 8'h08, 8'hff, 8'hff, 8'hff}, 0, -1);
        check(8'(WRITE_EN_LATCH), 8'h00);
        // hold just before a one bit, so a lost bit shows
        send('{8'h13, 8'h00, 8'h00}, 0, 22);
        check(rx, 8'h02);
        // updates stopped while the write bit is set, so values stand
        for (int k = 0; k < 3; k++) begin
            send('{8'h13, 8'(8 + k), 8'h00}, 0, -1);
            check(rx, msk[k]);
        end
        // drop W with R set: counters load, visible time stays frozen
        send('{8'h06}, 0, -1);
        send('{8'h12, 8'h00, 8'h01}, 0, -1);
        s0 = n_st;
        send('{8'h06}, 0, -1);
        send('{8'h3c}, 0, -1);
        check(8'(n_st - s0), 8'h01);
        send('{8'h13, 8'h08, 8'h00}, 0, -1);
        check(rx, 8'h7f);
        // release R: visible seconds follow the loaded counter, 7f -> 70
        send('{8'h06}, 0, -1);
        send('{8'h12, 8'h00, 8'h00}, 0, -1);
        send('{8'h13, 8'h08, 8'h00}, 0, -1);
        check({rx[7:4], 4'h0}, 8'h70);
        check(8'(rx[3:0] != 4'hf), 8'h01);
        check(8'(u_spi_host_model.hold_float), 8'h01);
        conclude();
    end
endmodule
